// *** core/irap_pkg.sv ***
/*
  shared constants and carrier types for the i2c register access port.
  assumes a single system clock domain; bus pins are sampled asynchronously.
*/
package irap_pkg;

  // ****************************************************************
  // bus addresses
  // ****************************************************************
  localparam logic [6:0] OWN_ADDR       = 7'h5a;  // fixed peripheral address (0xb4 write, 0xb5 read)
  localparam logic [6:0] BCAST_ADDR     = 7'h58;  // shared broadcast address

  // ****************************************************************
  // register map access, synchroniser and bit counting
  // ****************************************************************
  localparam int         REG_AW         = 8;      // register pointer width
  localparam int         REG_DW         = 8;      // register data width
  localparam logic [7:0] PTR_RESET      = 8'h00;  // pointer after reset
  localparam int         SYNC_STAGES    = 2;      // input synchroniser depth
  localparam int         BIT_CNT_W      = 4;      // bit counter width
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;   // bits before the acknowledge slot

  // ****************************************************************
  // types
  // ****************************************************************
  // write request toward the register file
  typedef struct packed {
    logic             valid;  // one-cycle strobe
    logic             bcast;  // came in on the broadcast address
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] data;
  } irap_wr_t;

  // read request toward the register file
  typedef struct packed {
    logic             valid;  // one-cycle strobe
    logic [REG_AW-1:0] addr;
  } irap_rd_t;

  // protocol phase
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA
  } irap_state_t;

endpackage : irap_pkg

// *** core/irap_port.sv ***
/*
  i2c peripheral port giving a bus controller read and write access to the
  device register space, with optional broadcast address.
  assumes scl and sda arrive unsynchronised from pins with pull-ups, and that
  the register file answers a read request with data on the following cycle.
*/
// Behaviour
// - answer own seven-bit address, both directions
// - also answer broadcast address when enabled
// - broadcast trigger write reaches all drivers together
// - serve accesses in standby and active states
// - bits shift msb first, one per clock
// - receiver acknowledges after every byte
// - sda changes only while scl low
// - acknowledge holds sda low whole period
// - no limit on bytes per transfer
// - every register single or multi byte
// - read returns bytes while controller acknowledges
// - register byte sets target, data increments
// - acknowledge matching address before register byte
// - acknowledge register byte before data
// - acknowledge each received write data byte
// - read uses register write, repeated start
// - zero trigger write forces standby state
`timescale 1ns/100ps
module irap_port #(
  parameter int AW = irap_pkg::REG_AW  // register pointer width
) (
  input  wire logic                clk_i,           // system clock, 50 mhz
  input  wire logic                rst_i,           // asynchronous reset, active high
  input  wire logic                scl_i,           // bus clock pin level
  input  wire logic                sda_i,           // bus data pin level
  output logic                     sda_o,           // data drive value (always low when enabled)
  output logic                     sda_oe_o,        // high while the port pulls sda
  input  wire logic                broadcast_respond_enable_i, // answer broadcast address too
  output irap_pkg::irap_wr_t       wr_o,            // register write strobe
  output irap_pkg::irap_rd_t       rd_o,            // register read strobe
  input  wire logic [irap_pkg::REG_DW-1:0] rd_data_i, // read data, one cycle after rd_o
  output logic                     busy_o           // addressed transfer in progress
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (AW != irap_pkg::REG_AW) begin : g_aw_chk
    $error("irap_port: register pointer must be one byte wide");
  end

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  logic [irap_pkg::SYNC_STAGES-1:0] scl_sync_reg;  // scl synchroniser chain
  logic [irap_pkg::SYNC_STAGES-1:0] sda_sync_reg;  // sda synchroniser chain
  logic                             scl_d_reg;     // delayed synced scl
  logic                             sda_d_reg;     // delayed synced sda
  logic                             scl_s;         // synced scl
  logic                             sda_s;         // synced sda
  logic                             scl_rise;      // scl rising edge
  logic                             scl_fall;      // scl falling edge
  logic                             start_det;     // start or repeated start
  logic                             stop_det;      // stop condition

  // two flip-flops before any logic reads the pins
  // reset to the idle high level so no false edge follows reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sync_reg <= '1;
      sda_sync_reg <= '1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
    end
  end

  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];

  // one-cycle history for edge detection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // start and stop are told apart from data by sda moving while scl is high
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ****************************************************************
  // protocol state
  // ****************************************************************
  irap_pkg::irap_state_t              state_reg;     // current phase
  logic [irap_pkg::BIT_CNT_W-1:0]     bit_cnt_reg;   // bits taken in this byte
  logic [7:0]                         shift_reg;     // receive / transmit shifter
  logic [AW-1:0]                      ptr_reg;       // register pointer
  logic                               rnw_reg;       // current address direction
  logic                               bcast_reg;     // addressed via broadcast
  logic                               mack_reg;      // controller ack seen on read
  logic                               load_pend_reg; // read data due from register file
  logic                               addr_hit;      // received address matches
  logic                               byte_done;     // eighth bit sampled

  // address match against own and enabled broadcast address
  function automatic logic addr_match(input logic [6:0] a, input logic bc_en);
    addr_match = (a == irap_pkg::OWN_ADDR) | (bc_en & (a == irap_pkg::BCAST_ADDR));
  endfunction : addr_match

  // at the eighth bit the shifter holds only the seven address bits, in its low end,
  // while the direction bit stands on the synced pin
  assign addr_hit  = addr_match(shift_reg[6:0], broadcast_respond_enable_i);
  assign byte_done = scl_rise & (bit_cnt_reg == irap_pkg::BITS_PER_BYTE - 4'h1);

  // bit counter: counts sampled bits within each byte, cleared on ack slot
  // it runs in idle too, but every start clears it before the next byte counts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_reg <= '0;
    end else if (start_det || stop_det) begin
      bit_cnt_reg <= '0;
    end else if (scl_rise) begin
      if (bit_cnt_reg == irap_pkg::BITS_PER_BYTE) begin
        bit_cnt_reg <= '0;  // ack slot sampled
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  // phase sequencing; no byte count limit anywhere
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= irap_pkg::ST_IDLE;
    end else if (stop_det) begin
      state_reg <= irap_pkg::ST_IDLE;
    end else if (start_det) begin
      state_reg <= irap_pkg::ST_ADDR;       // repeated start also ends write
    end else begin
      unique case (state_reg)
        irap_pkg::ST_IDLE: begin
          state_reg <= irap_pkg::ST_IDLE;
        end
        irap_pkg::ST_ADDR: begin
          if (byte_done) begin
            // unmatched address: drop out and stay released
            state_reg <= addr_hit ? irap_pkg::ST_ADDR_ACK : irap_pkg::ST_IDLE;
          end
        end
        irap_pkg::ST_ADDR_ACK: begin
          // leave on the scl fall that closes the acknowledge slot
          if (scl_fall && bit_cnt_reg == 4'h0) begin
            state_reg <= rnw_reg ? irap_pkg::ST_RDATA : irap_pkg::ST_REG;
          end
        end
        irap_pkg::ST_REG: begin
          if (byte_done) begin
            state_reg <= irap_pkg::ST_REG_ACK;
          end
        end
        irap_pkg::ST_REG_ACK: begin
          if (scl_fall && bit_cnt_reg == 4'h0) begin
            state_reg <= irap_pkg::ST_WDATA;
          end
        end
        irap_pkg::ST_WDATA: begin
          if (byte_done) begin
            state_reg <= irap_pkg::ST_WDATA_ACK;
          end
        end
        irap_pkg::ST_WDATA_ACK: begin
          if (scl_fall && bit_cnt_reg == 4'h0) begin
            state_reg <= irap_pkg::ST_WDATA;
          end
        end
        irap_pkg::ST_RDATA: begin
          // controller not-acknowledge ends our driving
          if (scl_fall && bit_cnt_reg == 4'h0 && !mack_reg) begin
            state_reg <= irap_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // a read byte is loaded while scl is still high in the acknowledge slot, ahead of its msb
  // receive shifter, msb first, and transmit shifter on read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= '0;
    end else if (load_pend_reg) begin
      shift_reg <= rd_data_i;
    end else if (state_reg == irap_pkg::ST_RDATA) begin
      if (scl_fall && bit_cnt_reg != 4'h0 && bit_cnt_reg != irap_pkg::BITS_PER_BYTE) begin
        shift_reg <= {shift_reg[6:0], 1'b0};  // next bit out after low edge
      end
    end else if (scl_rise && bit_cnt_reg != irap_pkg::BITS_PER_BYTE) begin
      shift_reg <= {shift_reg[6:0], sda_s};
    end
  end

  // direction and broadcast flag captured from the address byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rnw_reg   <= 1'b0;
      bcast_reg <= 1'b0;
    end else if (state_reg == irap_pkg::ST_ADDR && byte_done) begin
      rnw_reg   <= sda_s;
      // marks every data write of this frame for the trigger fan-out
      bcast_reg <= (shift_reg[6:0] == irap_pkg::BCAST_ADDR);
    end
  end

  // controller acknowledge sampled in the read ack slot
  // a not-acknowledge leaves it low, which ends the read at the next scl fall
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mack_reg <= 1'b0;
    end else if (state_reg == irap_pkg::ST_RDATA && scl_rise && bit_cnt_reg == irap_pkg::BITS_PER_BYTE) begin
      mack_reg <= ~sda_s;
    end
  end

  // ****************************************************************
  // register pointer and register file strobes
  // ****************************************************************
  logic rd_go;  // fetch next read byte

  // fetch on the rising edge of the acknowledge slot, so the byte sits in the shifter before
  // scl falls again; a short scl low time leaves no room to fetch after the fall.
  // the first byte follows our own address acknowledge, later ones a controller acknowledge
  assign rd_go = scl_rise && (bit_cnt_reg == irap_pkg::BITS_PER_BYTE)
               && ((state_reg == irap_pkg::ST_ADDR_ACK && rnw_reg)
                   || (state_reg == irap_pkg::ST_RDATA && !sda_s));

  // pointer: set by register byte, advances after each data byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_reg <= irap_pkg::PTR_RESET;
    end else if (state_reg == irap_pkg::ST_REG && byte_done) begin
      ptr_reg <= {shift_reg[6:0], sda_s};
    end else if ((state_reg == irap_pkg::ST_WDATA && byte_done) || rd_go) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // write strobe per data byte, independent of standby or active
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_o <= '0;
    end else begin
      wr_o.valid <= (state_reg == irap_pkg::ST_WDATA) && byte_done;
      wr_o.bcast <= bcast_reg;
      wr_o.addr  <= ptr_reg;
      wr_o.data  <= {shift_reg[6:0], sda_s};
    end
  end

  // read strobe per byte, data loaded into the shifter two cycles later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_o          <= '0;
      load_pend_reg <= 1'b0;
    end else begin
      rd_o.valid    <= rd_go;
      rd_o.addr     <= ptr_reg;
      load_pend_reg <= rd_o.valid;
    end
  end

  // ****************************************************************
  // sda drive
  // ****************************************************************
  logic drive_next;  // next output enable

  // pull sda for ack slots and read zeros, changes follow scl low
  // apart from the release on a start or stop, the drive moves only on a detected scl fall, so those changes land inside scl low
  // even with the synchroniser lag; in between the last value simply holds
  always_comb begin
    drive_next = sda_oe_o;
    if (start_det || stop_det) begin
      drive_next = 1'b0;                               // a frame edge always releases
    end else if (scl_fall) begin
      unique case (state_reg)
        irap_pkg::ST_ADDR_ACK: begin
          // acknowledge the address, then on a read put out the first msb
          drive_next = (bit_cnt_reg == irap_pkg::BITS_PER_BYTE)
                     | ((bit_cnt_reg == 4'h0) & rnw_reg & ~shift_reg[7]);
        end
        irap_pkg::ST_REG_ACK:   drive_next = (bit_cnt_reg == irap_pkg::BITS_PER_BYTE);
        irap_pkg::ST_WDATA_ACK: drive_next = (bit_cnt_reg == irap_pkg::BITS_PER_BYTE);
        irap_pkg::ST_RDATA: begin
          if (bit_cnt_reg == irap_pkg::BITS_PER_BYTE) begin
            drive_next = 1'b0;                         // release for the controller acknowledge
          end else if (bit_cnt_reg == 4'h0) begin
            drive_next = mack_reg & ~shift_reg[7];     // msb of the byte just fetched
          end else begin
            drive_next = ~shift_reg[6];                // bit the shifter moves up at this fall
          end
        end
        default:                drive_next = 1'b0;
      endcase
    end
  end

  // registered open-drain drive
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_oe_o <= 1'b0;
    end else begin
      sda_oe_o <= drive_next;
    end
  end

  // drive value is always low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // busy when addressed
  // the address phase itself does not count, so foreign frames never raise it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_reg != irap_pkg::ST_IDLE) && (state_reg != irap_pkg::ST_ADDR);
    end
  end

endmodule : irap_port

// *** tb/i2c_register_access_port_test.sv ***
/* self-checking bench for the register access port.
   assumes the host model and a register file model beside the port. */
`timescale 1ns/100ps
module i2c_register_access_port_test;
  // ****************************************************************
  // signals and models
  // ****************************************************************
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               bc_en = 1'b0;    // broadcast answer enable
  logic [7:0]         rd_data = 8'h00; // register file read data
  logic               dut_oe, dut_sdo, busy, host_oe, scl, last_bc;
  wire  logic         sda = (dut_oe ? dut_sdo : 1'b1) & ~host_oe;  // wired-and, pull-up
  irap_pkg::irap_wr_t wr;
  irap_pkg::irap_rd_t rd;
  logic [7:0]         mem [256];     // register file model
  logic [7:0]         shadow [256];  // expected contents
  int                 mismatches = 0;
  int                 num_checks = 0;
  int                 n_wr = 0;
  always #10 clk_i = ~clk_i;
  irap_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(dut_sdo),
    .sda_oe_o(dut_oe), .broadcast_respond_enable_i(bc_en), .wr_o(wr), .rd_o(rd),
    .rd_data_i(rd_data), .busy_o(busy));
  irap_host_model host_u (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  initial for (int i = 0; i < 256; i++) {mem[i], shadow[i]} = {2{8'(i) ^ 8'h3c}};
  // register file: writes land, reads answer next cycle
  always @(posedge clk_i) begin
    if (wr.valid) begin
      mem[wr.addr] <= wr.data;
      last_bc <= wr.bcast;
      n_wr <= n_wr + 1;
    end
    if (rd.valid) rd_data <= mem[rd.addr];
  end
  // ****************************************************************
  // compare and sequence helpers
  // ****************************************************************
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic put(input logic [7:0] d, input logic e);
    logic a;
    host_u.wbyte(d, a);
    chk1("ack", e, a);
  endtask : put
  task automatic wr_seq(input logic [7:0] dev, input logic [7:0] base, input int n, input logic [7:0] d0);
    host_u.start();
    put(dev, 1'b1);
    chk1("busy", 1'b1, busy);
    put(base, 1'b1);
    for (int i = 0; i < n; i++) begin
      put(8'(d0 + i), 1'b1);
      shadow[8'(base + i)] = 8'(d0 + i);
    end
    host_u.stop();
    repeat (4) @(posedge clk_i);
    chk1("busy", 1'b0, busy);
    for (int i = 0; i < n; i++) chk8("wr", shadow[8'(base + i)], mem[8'(base + i)]);
  endtask : wr_seq
  task automatic rd_seq(input logic [7:0] base, input int n);
    logic [7:0] d;
    host_u.start();
    put(8'hb4, 1'b1);
    put(base, 1'b1);
    host_u.start();
    put(8'hb5, 1'b1);
    for (int i = 0; i < n; i++) begin
      host_u.rbyte(i != n - 1, d);
      chk8("rd", shadow[8'(base + i)], d);
    end
    host_u.stop();
  endtask : rd_seq
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_single();
    wr_seq(8'hb4, 8'h10, 1, 8'h81);
    rd_seq(8'h10, 1);
  endtask : t_single
  task automatic t_multi();
    wr_seq(8'hb4, 8'h20, 4, 8'ha0);
    rd_seq(8'h1f, 6);
  endtask : t_multi
  task automatic t_wrap();
    wr_seq(8'hb4, 8'hf8, 20, 8'h40);
    rd_seq(8'hfe, 4);
  endtask : t_wrap
  task automatic t_foreign();
    int n0 = n_wr;
    host_u.start();
    put(8'hb6, 1'b0);
    chk1("busy", 1'b0, busy);
    put(8'h00, 1'b0);
    host_u.stop();
    host_u.start();
    put(8'hb0, 1'b0);
    put(8'h00, 1'b0);
    host_u.stop();
    chk8("writes", 8'(n0), 8'(n_wr));
  endtask : t_foreign
  task automatic t_bcast();
    bc_en <= 1'b1;
    wr_seq(8'hb0, 8'h0c, 1, 8'h01);
    chk1("bcast", 1'b1, last_bc);
    rd_seq(8'h0c, 1);
    wr_seq(8'hb0, 8'h0c, 1, 8'h00);
    wr_seq(8'hb4, 8'h0d, 1, 8'h77);
    chk1("bcast", 1'b0, last_bc);
    bc_en <= 1'b0;
  endtask : t_bcast
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    t_single();
    t_multi();
    t_wrap();
    t_foreign();
    t_bcast();
    give_verdict();
  end
  // watchdog, about four times the expected run
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule : i2c_register_access_port_test

// *** tb/irap_host_model.sv ***
/* bus controller model: frames, bytes and acks, 8 clk per bit (160 ns scl).
   assumes the bench resolves sda with a pull-up. */
`timescale 1ns/100ps
module irap_host_model (
  input  wire logic clk_i,    // pacing clock
  input  wire logic sda_i,    // resolved data line
  output logic      scl_o,    // bus clock, still outside frames
  output logic      sda_oe_o  // high while pulling sda low
);
  initial {scl_o, sda_oe_o} = 2'b10;
  // quarter bit; four clocks of scl low still cover the port's three-clock drive lag
  task automatic q();
    repeat (2) @(posedge clk_i);
  endtask : q
  // start or repeated start
  task automatic start();
    q(); sda_oe_o <= 1'b0;
    q(); scl_o <= 1'b1;
    q(); sda_oe_o <= 1'b1;
    q(); scl_o <= 1'b0;
  endtask : start
  task automatic stop();
    q(); sda_oe_o <= 1'b1;
    q(); scl_o <= 1'b1;
    q(); sda_oe_o <= 1'b0;
    q();
  endtask : stop
  // one bit, data changed only while scl low
  task automatic bit_x(input logic b, output logic s);
    q(); sda_oe_o <= !b;
    q(); scl_o <= 1'b1;
    q(); #1 s = sda_i;
    q(); scl_o <= 1'b0;
  endtask : bit_x
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask : wbyte
  // ack all bytes but the last, which gets a not-ack
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!ack, s);
  endtask : rbyte
endmodule : irap_host_model

// *** tb/irap_port_monitor.sv ***
/* protocol checker for the register access port.
   assumes pins change on clock edges and sda has a pull-up. */
`timescale 1ns/100ps
module irap_port_monitor (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               scl_i,
  input wire logic               sda_i,
  input wire logic               sda_o,
  input wire logic               sda_oe_o,
  input wire logic               broadcast_respond_enable_i,
  input wire irap_pkg::irap_wr_t wr_o,
  input wire irap_pkg::irap_rd_t rd_o,
  input wire logic [7:0]         rd_data_i,
  input wire logic               busy_o
);
  // ****************************************************************
  // helper state
  // ****************************************************************
  logic       sda_q;           // pin level one cycle back
  logic       seen_w, seen_r;  // a byte already moved in this frame
  logic [7:0] last_w, last_r;  // pointer of that byte
  wire  logic st = scl_i & sda_q & ~sda_i;  // start on the pins
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // delayed data pin
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) sda_q <= 1'b1;
    else sda_q <= sda_i;
  end
  // last pointer per direction; its seen flag cleared by each start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {seen_w, seen_r, last_w, last_r} <= '0;
    end else if (st) begin
      {seen_w, seen_r} <= 2'b00;
    end else begin
      if (wr_o.valid) {seen_w, last_w} <= {1'b1, wr_o.addr};
      if (rd_o.valid) {seen_r, last_r} <= {1'b1, rd_o.addr};
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  sequence s_stop; scl_i && sda_i && !sda_q; endsequence
  sequence s_ack; ##[1:20] sda_oe_o; endsequence
  property p_low; sda_oe_o |-> !sda_o; endproperty
  a_low: assert property (p_low) else $error("sda driven high");
  property p_chg; $changed(sda_oe_o) |-> !scl_i && !$past(scl_i); endproperty
  a_chg: assert property (p_chg) else $error("sda moved with scl high");
  property p_aack; $rose(busy_o) |-> s_ack; endproperty
  a_aack: assert property (p_aack) else $error("no address ack");
  property p_dack; wr_o.valid |-> s_ack; endproperty
  a_dack: assert property (p_dack) else $error("no data ack");
  property p_sel; $rose(sda_oe_o) |-> busy_o; endproperty
  a_sel: assert property (p_sel) else $error("drive while unselected");
  property p_wpl; wr_o.valid |-> busy_o ##1 !wr_o.valid; endproperty
  a_wpl: assert property (p_wpl) else $error("bad write strobe");
  property p_rpl; rd_o.valid |-> busy_o ##1 !rd_o.valid; endproperty
  a_rpl: assert property (p_rpl) else $error("bad read strobe");
  property p_wst; wr_o.valid && seen_w |-> wr_o.addr == last_w + 8'h01; endproperty
  a_wst: assert property (p_wst) else $error("write pointer step");
  property p_rst; rd_o.valid && seen_r |-> rd_o.addr == last_r + 8'h01; endproperty
  a_rst: assert property (p_rst) else $error("read pointer step");
  property p_end; s_stop |-> ##[1:8] !busy_o; endproperty
  a_end: assert property (p_end) else $error("busy after stop");
  property p_bc; wr_o.valid && wr_o.bcast |-> broadcast_respond_enable_i; endproperty
  a_bc: assert property (p_bc) else $error("broadcast while disabled");
endmodule : irap_port_monitor
bind irap_port irap_port_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .broadcast_respond_enable_i(broadcast_respond_enable_i),
  .wr_o(wr_o), .rd_o(rd_o), .rd_data_i(rd_data_i), .busy_o(busy_o));
